// ---- common/cmpev_regs.vh ----
`ifndef CMPEV_REGS_VH
`define CMPEV_REGS_VH
// register byte offsets (one aligned word each)
`define CMPEV_OFF_CTRL1     12'h000
`define CMPEV_OFF_CTRL2     12'h004
`define CMPEV_OFF_CTRL3     12'h008
`define CMPEV_OFF_CTRL4     12'h00c
`define CMPEV_OFF_MSK1      12'h010
`define CMPEV_OFF_MSK2      12'h014
`define CMPEV_OFF_MSK3      12'h018
`define CMPEV_OFF_MSK4      12'h01c
// control register fields
`define CMPEV_B_ENABLE      15
`define CMPEV_B_PIN_OE      14
`define CMPEV_B_POL_INV     13
`define CMPEV_B_AMP_PIN     11
`define CMPEV_B_AMP_FUNC    10
`define CMPEV_B_EVT         9
`define CMPEV_B_RESULT      8
`define CMPEV_B_EDGE_HI     7
`define CMPEV_B_EDGE_LO     6
`define CMPEV_B_REF_SEL     4
`define CMPEV_B_CH_HI       1
`define CMPEV_B_CH_LO       0
// writable bits of each control register
// the event flag is left out: software may clear it but never set it
`define CMPEV_CTRL_WMASK    16'hecd3
`define CMPEV_CTRL4_WMASK   16'he0d3
`define CMPEV_MSK_WMASK     16'h0fff
`define CMPEV_RST16         16'h0000
// event edge encodings
`define CMPEV_EDGE_OFF      2'b00
`define CMPEV_EDGE_RISE     2'b01
`define CMPEV_EDGE_FALL     2'b10
`define CMPEV_EDGE_ANY      2'b11
// negative input channel codes
`define CMPEV_CH_FIRST      2'b00
`define CMPEV_CH_SECOND     2'b01
// mask source codes
`define CMPEV_SRC_PWM_LAST  4'h5
`define CMPEV_SRC_TRIG18    4'hc
`define CMPEV_SRC_TRIG19    4'hd
`define CMPEV_SRC_FAULT_INPUT_TWO      4'he
`define CMPEV_SRC_FAULT_INPUT_FOUR      4'hf
`endif

// ---- hdl/cmpev_mask_mux.v ----
`timescale 1ns/100ps
`include "cmpev_regs.vh"
module cmpev_mask_mux (
  input  wire [3:0] sel,
  input  wire [5:0] pwm_out,
  input  wire       trigger_generator_output_eighteen,
  input  wire       trigger_generator_output_nineteen,
  input  wire       fault_input_two,
  input  wire       fault_input_four,
  output reg        mask_out
);
  always @* begin
    mask_out = 1'b0;
    if (sel <= `CMPEV_SRC_PWM_LAST) begin
      mask_out = pwm_out[sel[2:0]];
    end else begin
      case (sel)
        `CMPEV_SRC_TRIG18: mask_out = trigger_generator_output_eighteen;
        `CMPEV_SRC_TRIG19: mask_out = trigger_generator_output_nineteen;
        `CMPEV_SRC_FAULT_INPUT_TWO:   mask_out = fault_input_two;
        `CMPEV_SRC_FAULT_INPUT_FOUR:   mask_out = fault_input_four;
        // reserved codes give a quiet low mask
        default:           mask_out = 1'b0;
      endcase
    end
  end
endmodule

// ---- hdl/cmpev_top.v ----
// Operation
// - comparator works only while its enable bit 15 is set
// - bit 14 drives the result onto the output pin, else internal only
// - bit 13 inverts result before status, pin and event logic
// - status bit 8 reads the polarity-adjusted result
// - bit 10 selects amplifier or comparator for units one to three
// - bit 11 connects amplifier output to its pin for units one to three
// - event flag bit 9 sets on selected edge and blocks further events
// - edge code 11 fires on any output change while flag clear
// - edge code 10 fires on falling adjusted output while flag clear
// - edge code 01 fires on rising adjusted output while flag clear
// - edge code 00 fires nothing
// - bit 4 routes positive input to reference or first positive pin
// - channel field picks first or second negative pin; 10 and 11 unused
// - fourth unit has no amplifier; bits 12-10 read zero
// - mask C source at bits 11-8; bits 15-12 read zero
// - mask B source at bits 7-4, same encoding
// - mask A at bits 3-0; codes select pwm and trigger outputs
// - 1110 fault two, 1111 fault four, 0110-1011 reserved
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "cmpev_regs.vh"
module cmpev_top (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  compare_raw,
  input  wire [5:0]  pwm_out,
  input  wire        trigger_generator_output_eighteen,
  input  wire        trigger_generator_output_nineteen,
  input  wire        fault_input_two,
  input  wire        fault_input_four,
  output reg  [3:0]  comparator_output_pin,
  output reg  [3:0]  compare_event,
  output reg  [3:0]  comparator_enable,
  output reg  [3:0]  positive_input_reference_select,
  output reg  [3:0]  negative_input_second_select,
  output reg  [2:0]  amplifier_function_select,
  output reg  [2:0]  amplifier_pin_connect,
  output reg  [3:0]  mask_a,
  output reg  [3:0]  mask_b,
  output reg  [3:0]  mask_c
);
  reg  [15:0] ctrl [0:3];
  reg  [15:0] msk  [0:3];
  reg  [3:0]  raw_meta;
  reg  [3:0]  raw_sync;
  reg  [3:0]  adj_prev;
  wire [3:0]  adj;
  wire [3:0]  fire;
  wire [3:0]  ma;
  wire [3:0]  mb;
  wire [3:0]  mc;
  wire        wr_en;
  wire        rd_en;
  wire        hit_ctrl;
  wire        hit_msk;
  wire [1:0]  idx;
  reg  [15:0] rd_word;

  assign wr_en    = psel & penable & pwrite & ~pready;
  assign rd_en    = psel & penable & ~pwrite & ~pready;
  assign idx      = paddr[3:2];
  assign hit_ctrl = (paddr[11:4] == `CMPEV_OFF_CTRL1 >> 4) && (paddr[1:0] == 2'b00);
  assign hit_msk  = (paddr[11:4] == `CMPEV_OFF_MSK1 >> 4) && (paddr[1:0] == 2'b00);

  // two-flop sync of the analog comparator results
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw_meta <= 4'h0;
      raw_sync <= 4'h0;
    end else begin
      raw_meta <= compare_raw;
      raw_sync <= raw_meta;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : unit
      wire en  = ctrl[g][`CMPEV_B_ENABLE];
      wire inv = ctrl[g][`CMPEV_B_POL_INV];
      wire [1:0] edge_sel = ctrl[g][`CMPEV_B_EDGE_HI:`CMPEV_B_EDGE_LO];
      // a disabled unit reads as low; events are gated by enable so disable makes none
      assign adj[g] = en & (raw_sync[g] ^ inv);
      reg f;
      always @* begin
        case (edge_sel)
          `CMPEV_EDGE_ANY:  f = adj[g] ^ adj_prev[g];
          `CMPEV_EDGE_FALL: f = ~adj[g] & adj_prev[g];
          `CMPEV_EDGE_RISE: f = adj[g] & ~adj_prev[g];
          default:          f = 1'b0;
        endcase
      end
      assign fire[g] = f & en & ~ctrl[g][`CMPEV_B_EVT];
      cmpev_mask_mux u_mux_a (
        .sel                               (msk[g][3:0]),
        .pwm_out                           (pwm_out),
        .trigger_generator_output_eighteen (trigger_generator_output_eighteen),
        .trigger_generator_output_nineteen (trigger_generator_output_nineteen),
        .fault_input_two                   (fault_input_two),
        .fault_input_four                  (fault_input_four),
        .mask_out                          (ma[g])
      );
      cmpev_mask_mux u_mux_b (
        .sel                               (msk[g][7:4]),
        .pwm_out                           (pwm_out),
        .trigger_generator_output_eighteen (trigger_generator_output_eighteen),
        .trigger_generator_output_nineteen (trigger_generator_output_nineteen),
        .fault_input_two                   (fault_input_two),
        .fault_input_four                  (fault_input_four),
        .mask_out                          (mb[g])
      );
      cmpev_mask_mux u_mux_c (
        .sel                               (msk[g][11:8]),
        .pwm_out                           (pwm_out),
        .trigger_generator_output_eighteen (trigger_generator_output_eighteen),
        .trigger_generator_output_nineteen (trigger_generator_output_nineteen),
        .fault_input_two                   (fault_input_two),
        .fault_input_four                  (fault_input_four),
        .mask_out                          (mc[g])
      );
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          ctrl[g] <= `CMPEV_RST16;
          msk[g]  <= `CMPEV_RST16;
        end else begin
          if (wr_en && hit_ctrl && idx == g) begin
            // software may only clear the flag; a same-cycle event still sets it
            ctrl[g] <= (pwdata[15:0] & ((g == 3) ? `CMPEV_CTRL4_WMASK
                                                   : `CMPEV_CTRL_WMASK))
                       | ({15'h0, fire[g] | (ctrl[g][`CMPEV_B_EVT]
                          & pwdata[`CMPEV_B_EVT])} << `CMPEV_B_EVT);
          end else if (fire[g]) begin
            ctrl[g][`CMPEV_B_EVT] <= 1'b1;
          end
          if (wr_en && hit_msk && idx == g)
            msk[g] <= pwdata[15:0] & `CMPEV_MSK_WMASK;
        end
      end
    end
  endgenerate

  always @* begin
    rd_word = 16'h0000;
    if (hit_ctrl) begin
      rd_word = ctrl[idx];
      rd_word[`CMPEV_B_RESULT] = adj[idx];
    end else if (hit_msk) begin
      rd_word = msk[idx];
    end
  end

  integer i;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata                          <= 32'h0000_0000;
      pready                          <= 1'b0;
      pslverr                         <= 1'b0;
      adj_prev                        <= 4'h0;
      comparator_output_pin           <= 4'h0;
      compare_event                   <= 4'h0;
      comparator_enable               <= 4'h0;
      positive_input_reference_select <= 4'h0;
      negative_input_second_select    <= 4'h0;
      amplifier_function_select       <= 3'h0;
      amplifier_pin_connect           <= 3'h0;
      mask_a                          <= 4'h0;
      mask_b                          <= 4'h0;
      mask_c                          <= 4'h0;
    end else begin
      // one wait state: access phase is answered on its second edge
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(hit_ctrl | hit_msk);
      if (rd_en)
        prdata <= {16'h0000, rd_word};
      adj_prev      <= adj;
      compare_event <= fire;
      mask_a        <= ma;
      mask_b        <= mb;
      mask_c        <= mc;
      for (i = 0; i < 4; i = i + 1) begin
        comparator_enable[i]     <= ctrl[i][`CMPEV_B_ENABLE];
        comparator_output_pin[i] <= adj[i] & ctrl[i][`CMPEV_B_PIN_OE];
        positive_input_reference_select[i] <= ctrl[i][`CMPEV_B_REF_SEL];
        // codes 10 and 11 fall back to the first pin
        negative_input_second_select[i] <=
          (ctrl[i][`CMPEV_B_CH_HI:`CMPEV_B_CH_LO] == `CMPEV_CH_SECOND);
      end
      for (i = 0; i < 3; i = i + 1) begin
        amplifier_function_select[i] <= ctrl[i][`CMPEV_B_AMP_FUNC];
        amplifier_pin_connect[i]     <= ctrl[i][`CMPEV_B_AMP_PIN];
      end
    end
  end
endmodule

// ---- tb/cmpev_top_props.sv ----
`timescale 1ns/100ps
module cmpev_top_props (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire [3:0]  compare_event,
  input wire [3:0]  comparator_enable,
  input wire [3:0]  positive_input_reference_select,
  input wire [3:0]  negative_input_second_select,
  input wire [2:0]  amplifier_function_select,
  input wire [2:0]  amplifier_pin_connect
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable && !pready;
  wire wr  = psel && penable && pwrite;
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_READY_TAKE: assert property (acc |=> pready) else $error("pready late");
  AST_ERR_DECODE: assert property (acc && paddr[1:0] == 2'b00 |=>
    pslverr == ($past(paddr) > 12'h01c)) else $error("bad pslverr");
  AST_EVT_SINGLE: assert property ((compare_event & $past(compare_event)) == 4'h0)
    else $error("event twice");
  AST_EVT_NEEDS_EN: assert property (
    (compare_event & ~(comparator_enable | $past(comparator_enable))) == 4'h0)
    else $error("event while disabled");
  // registered copies may lag the write by one or two edges
  AST_EN_FOLLOWS_WRITE: assert property (
    $changed(comparator_enable) |-> $past(wr, 1) || $past(wr, 2)) else $error("enable moved");
  AST_AMP_FOLLOWS_WRITE: assert property (
    $changed({amplifier_function_select, amplifier_pin_connect}) |-> $past(wr, 1) || $past(wr, 2))
    else $error("amplifier moved");
  AST_REF_FOLLOWS_WRITE: assert property (
    !$past(wr, 1) && !$past(wr, 2) |-> $stable(positive_input_reference_select))
    else $error("reference moved");
  AST_CH_FOLLOWS_WRITE: assert property (
    $rose(negative_input_second_select[0]) |-> $past(wr, 1) || $past(wr, 2))
    else $error("channel moved");
  cover property (compare_event[1]);
  cover property (pready && pslverr);
  cover property (acc && pwrite);
endmodule

bind cmpev_top cmpev_top_props u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .compare_event(compare_event),
  .comparator_enable(comparator_enable),
  .positive_input_reference_select(positive_input_reference_select),
  .negative_input_second_select(negative_input_second_select),
  .amplifier_function_select(amplifier_function_select),
  .amplifier_pin_connect(amplifier_pin_connect)
);

// ---- tb/cmpev_top_tb.sv ----
`timescale 1ns/100ps
`include "cmpev_regs.vh"
module cmpev_top_tb;
  reg         clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, rd;
  reg  [3:0]  raw = 0;
  reg  [5:0]  pwm = 0;
  reg         t18 = 0, t19 = 0, f2 = 0, f4 = 0, err;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire [3:0]  pin, evt, en, refs, neg2, ma, mb, mc;
  wire [2:0]  amf, amp;
  integer     err_count = 0, comparisons = 0, i, k, n;
  cmpev_top DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_raw(raw), .pwm_out(pwm), .trigger_generator_output_eighteen(t18),
    .trigger_generator_output_nineteen(t19), .fault_input_two(f2), .fault_input_four(f4),
    .comparator_output_pin(pin), .compare_event(evt), .comparator_enable(en),
    .positive_input_reference_select(refs), .negative_input_second_select(neg2),
    .amplifier_function_select(amf), .amplifier_pin_connect(amp),
    .mask_a(ma), .mask_b(mb), .mask_c(mc));
  initial forever #20 clk_sys = ~clk_sys;
  task results;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys);
      penable <= 1;
      n = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_sys);
      end
      if (n == 20) begin
        err_count = err_count + 1;
        results;
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        apb(0, i * 4, 0);
        chk(rd, 0);
      end
      apb(1, `CMPEV_OFF_CTRL1, 32'hffffdfff);
      apb(1, `CMPEV_OFF_CTRL4, 32'hffffdfff);
      apb(0, `CMPEV_OFF_CTRL1, 0);
      chk(rd, 32'hccd3);
      apb(0, `CMPEV_OFF_CTRL4, 0);
      chk(rd, 32'hc0d3);
      chk({en, amf, amp, refs, neg2}, {4'h9, 3'h1, 3'h1, 4'h9, 4'h0});
      apb(1, `CMPEV_OFF_CTRL1, 32'h1);
      apb(1, `CMPEV_OFF_CTRL4, 0);
      repeat (2) @(posedge clk_sys);
      chk({en, amf, amp, refs, neg2}, {4'h0, 3'h0, 3'h0, 4'h0, 4'h1});
      apb(1, 12'h020, 32'hffff);
      chk(err, 1);
      apb(0, 12'h020, 0);
      chk({err, rd[30:0]}, 32'h80000000);
    end
  endtask
  task t_mask;
    reg [9:0] p;
    reg [3:0] c;
    reg       e;
    begin
      for (k = 0; k < 32; k = k + 1) begin
        p = k[4] ? 10'h155 : 10'h2aa;
        c = k[3:0];
        @(posedge clk_sys);
        {f4, f2, t19, t18, pwm} <= p;
        apb(1, `CMPEV_OFF_MSK1, {20'hfffff, c, c, c});
        apb(0, `CMPEV_OFF_MSK1, 0);
        chk(rd, {20'h0, c, c, c});
        e = c < 6 ? p[c] : c > 11 ? p[c - 6] : 1'b0;
        chk({ma[0], mb[0], mc[0]}, {3{e}});
      end
    end
  endtask
  task t_event;
    reg [15:0] cw;
    integer    pol, code, fired, cnt;
    begin
      for (pol = 0; pol < 2; pol = pol + 1)
        for (code = 0; code < 4; code = code + 1) begin
          @(posedge clk_sys);
          raw[1] <= pol[0];
          repeat (4) @(posedge clk_sys);
          // raw equals polarity so enabling makes no adjusted edge
          cw = {1'b1, code[1], pol[0], 5'h0, code[1:0], 6'h0};
          apb(1, `CMPEV_OFF_CTRL2, {16'h0, cw});
          fired = 0;
          for (k = 0; k < 2; k = k + 1) begin
            @(posedge clk_sys);
            raw[1] <= ~raw[1];
            cnt = 0;
            repeat (8) begin
              @(posedge clk_sys);
              cnt = cnt + evt[1];
            end
            chk(cnt, fired == 0 && code[k]);
            fired = fired | cnt;
            chk(pin[1], k == 0 && code[1]);
            apb(0, `CMPEV_OFF_CTRL2, 0);
            chk(rd[8], k == 0);
          end
          chk(rd[9], fired != 0);
          apb(1, `CMPEV_OFF_CTRL2, {16'h0, cw});
          apb(0, `CMPEV_OFF_CTRL2, 0);
          chk(rd[9], 0);
          apb(1, `CMPEV_OFF_CTRL2, 0);
        end
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1;
    t_regs;
    t_mask;
    t_event;
    results;
  end
endmodule
